/* File: inc/lbm_pkg.sv */
// constants and helpers for the leaky bucket activity monitor
package lbm_pkg;
  // system clock and evaluation timing
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned EVAL_PERIOD_MS = 128;
  localparam int unsigned EVAL_CYCLES = EVAL_PERIOD_MS * (CLK_HZ / 1000);

  // register port widths
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int LEAK_W = 2;
  localparam int QUIET_W = 4;

  // register offsets
  localparam logic [7:0] SET_LVL2_ADDR = 8'h58;
  localparam logic [7:0] CLR_LVL2_ADDR = 8'h59;
  localparam logic [7:0] FILL_CAP2_ADDR = 8'h5a;
  localparam logic [7:0] LEAK2_ADDR = 8'h5b;
  localparam logic [7:0] SET_LVL3_ADDR = 8'h5c;
  localparam logic [7:0] CLR_LVL3_ADDR = 8'h5d;
  localparam logic [7:0] FILL_CAP3_ADDR = 8'h5e;
  localparam logic [7:0] LEAK3_ADDR = 8'h5f;
  localparam logic [7:0] ALARM_STAT_ADDR = 8'h70;

  // reset values
  localparam logic [7:0] SET_LVL_RST = 8'h06;
  localparam logic [7:0] CLR_LVL_RST = 8'h04;
  localparam logic [7:0] FILL_CAP_RST = 8'h08;
  localparam logic [1:0] LEAK_RST = 2'h1;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // leak codes
  localparam logic [1:0] LEAK_1 = 2'h0;
  localparam logic [1:0] LEAK_2 = 2'h1;
  localparam logic [1:0] LEAK_4 = 2'h2;

  typedef logic [REG_W-1:0] lbm_byte_type;

  // quiet evaluation cycles per decrement for a leak code
  function automatic logic [QUIET_W-1:0] leak_span(input logic [LEAK_W-1:0] code);
    unique case (code)
      LEAK_1: leak_span = 4'h1;
      LEAK_2: leak_span = 4'h2;
      LEAK_4: leak_span = 4'h4;
      default: leak_span = 4'h8;
    endcase
  endfunction
endpackage

/* File: core/lbm_bucket.sv */
// one leaky bucket integrator with hysteresis alarm
`timescale 1ns/100ps
`default_nettype none
module lbm_bucket (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic eval_tick_i,
  input wire logic fault_seen_i,
  input wire logic [7:0] set_level_i,
  input wire logic [7:0] clear_level_i,
  input wire logic [7:0] fill_cap_i,
  input wire logic [1:0] leak_code_i,
  output logic [7:0] fill_o,
  output logic alarm_o
);
  logic [7:0] fill; // accumulator
  logic [7:0] next_fill;
  logic [3:0] quiet; // quiet cycles since last failure or leak step
  logic [3:0] next_quiet;
  logic alarm; // alarm on accumulated failures
  logic next_alarm;
  logic [3:0] span; // quiet cycles per leak step

  assign span = lbm_pkg::leak_span(leak_code_i);
  assign fill_o = fill;
  assign alarm_o = alarm;

  // next accumulator, quiet count and alarm
  always_comb begin
    next_fill = fill;
    next_quiet = quiet;
    next_alarm = alarm;
    if (eval_tick_i) begin
      if (fault_seen_i) begin
        // failed cycle: fill by one, capped
        next_quiet = 4'h0;
        if (fill >= fill_cap_i) begin
          next_fill = fill_cap_i;
        end else begin
          next_fill = 8'(fill + 8'h01);
        end
      end else if (4'(quiet + 4'h1) >= span) begin
        // quiet interval complete: leak one
        next_quiet = 4'h0;
        if (fill > fill_cap_i) begin
          next_fill = fill_cap_i;
        end else if (fill != 8'h00) begin
          next_fill = 8'(fill - 8'h01);
        end else begin
          next_fill = 8'h00;
        end
      end else begin
        // still inside the quiet interval
        next_quiet = 4'(quiet + 4'h1);
        if (fill > fill_cap_i) begin
          next_fill = fill_cap_i;
        end
      end
      // raise has priority over clear
      if (next_fill >= set_level_i) begin
        next_alarm = 1'b1;
      end else if (next_fill <= clear_level_i) begin
        next_alarm = 1'b0;
      end
    end
  end

  // state registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fill <= 8'h00;
      quiet <= 4'h0;
      alarm <= 1'b0;
    end else begin
      fill <= next_fill;
      quiet <= next_quiet;
      alarm <= next_alarm;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_fill_step: assert property (eval_tick_i && fault_seen_i && fill < fill_cap_i |=>
    fill == $past(fill) + 8'h01)
    else $error("fill did not step up");
  a_fill_cap: assert property (eval_tick_i |=> fill <= $past(fill_cap_i))
    else $error("fill passed cap");
  a_leak_step: assert property (eval_tick_i && !fault_seen_i && 4'(quiet + 4'h1) >= span &&
    fill != 8'h00 && fill <= fill_cap_i |=> fill == $past(fill) - 8'h01)
    else $error("fill did not leak");
  a_leak_span: assert property (eval_tick_i && !fault_seen_i && leak_code_i == 2'h3 && quiet == 4'h3 |=>
    quiet == 4'h4)
    else $error("leak span wrong");
  a_zero_floor: assert property (eval_tick_i && !fault_seen_i && fill == 8'h00 |=> fill == 8'h00)
    else $error("fill wrapped below zero");
  a_idle_hold: assert property (!eval_tick_i |=> $stable(fill) && $stable(alarm))
    else $error("fill moved between ticks");
  a_alarm_raise: assert property (eval_tick_i ##1 fill >= $past(set_level_i) |-> alarm)
    else $error("alarm not raised");
  a_alarm_drop: assert property ($fell(alarm) |-> fill <= $past(clear_level_i) && $past(eval_tick_i))
    else $error("alarm dropped above clear level");
  c_alarm_rise: cover property ($rose(alarm));
  c_alarm_fall: cover property ($fell(alarm));
  c_cap_hold: cover property (eval_tick_i && fault_seen_i && fill == fill_cap_i);
endmodule
`default_nettype wire

/* File: core/lbm_monitor.sv */
// activity monitor top: config sets 2 and 3, timing, buckets
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - evaluate inputs every 128 ms cycle
// - failed or erratic cycle adds one
// - each quiet interval removes one
// - leak codes select 1,2,4,8 cycles
// - leak selector uses bits 1:0 only
// - alarm raised at set level
// - alarm cleared at clear level
// - accumulator clamped to fill cap at each evaluation tick
// - sets 2 and 3 independent, read/write
module lbm_monitor #(
  parameter int NUM_IN = 3, // monitored inputs
  parameter int unsigned EVAL_CYCLES = lbm_pkg::EVAL_CYCLES // clocks per cycle
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [NUM_IN-1:0] fault_i,
  input wire logic [NUM_IN-1:0] cfg3_sel_i,
  output logic [NUM_IN-1:0] alarm_o
);
  localparam int CNT_W = (EVAL_CYCLES > 1) ? $clog2(EVAL_CYCLES) : 1;

  // refuse settings the logic cannot serve
  generate
    if (NUM_IN < 1 || NUM_IN > lbm_pkg::REG_W) begin : g_bad_num
      $error("NUM_IN must be 1 to 8");
    end
    if (EVAL_CYCLES < 2) begin : g_bad_eval
      $error("EVAL_CYCLES must be at least 2");
    end
    // the register map assumes byte registers and two-bit leak codes
    if (lbm_pkg::REG_W != 8 || lbm_pkg::LEAK_W != 2) begin : g_bad_pkg
      $error("package widths must be 8 and 2");
    end
  endgenerate

  // configuration set 2
  lbm_pkg::lbm_byte_type alarm_set_level_cfg2;
  lbm_pkg::lbm_byte_type alarm_clear_level_cfg2;
  lbm_pkg::lbm_byte_type fill_cap_cfg2;
  logic [1:0] leak_interval_cfg2; // only low two bits kept
  // configuration set 3
  lbm_pkg::lbm_byte_type alarm_set_level_cfg3;
  lbm_pkg::lbm_byte_type alarm_clear_level_cfg3;
  lbm_pkg::lbm_byte_type fill_cap_cfg3;
  logic [1:0] leak_interval_cfg3;
  // next values of the register group
  lbm_pkg::lbm_byte_type next_alarm_set_level_cfg2;
  lbm_pkg::lbm_byte_type next_alarm_clear_level_cfg2;
  lbm_pkg::lbm_byte_type next_fill_cap_cfg2;
  logic [1:0] next_leak_interval_cfg2;
  lbm_pkg::lbm_byte_type next_alarm_set_level_cfg3;
  lbm_pkg::lbm_byte_type next_alarm_clear_level_cfg3;
  lbm_pkg::lbm_byte_type next_fill_cap_cfg3;
  logic [1:0] next_leak_interval_cfg3;
  // read data
  lbm_pkg::lbm_byte_type rdata;
  lbm_pkg::lbm_byte_type next_rdata;

  // evaluation cycle timer
  logic [CNT_W-1:0] eval_cnt;
  logic [CNT_W-1:0] next_eval_cnt;
  logic eval_tick; // last clock of a cycle

  // failure seen during the current cycle
  logic [NUM_IN-1:0] fault_seen;
  logic [NUM_IN-1:0] next_fault_seen;
  logic [NUM_IN-1:0] fault_close; // verdict handed to buckets
  logic [NUM_IN-1:0] alarm; // bucket alarms

  // alarm status byte, upper bits zero
  function automatic lbm_pkg::lbm_byte_type alarm_byte(input logic [NUM_IN-1:0] a);
    alarm_byte = '0;
    alarm_byte[NUM_IN-1:0] = a;
  endfunction

  // register writes
  always_comb begin
    next_alarm_set_level_cfg2 = alarm_set_level_cfg2;
    next_alarm_clear_level_cfg2 = alarm_clear_level_cfg2;
    next_fill_cap_cfg2 = fill_cap_cfg2;
    next_leak_interval_cfg2 = leak_interval_cfg2;
    next_alarm_set_level_cfg3 = alarm_set_level_cfg3;
    next_alarm_clear_level_cfg3 = alarm_clear_level_cfg3;
    next_fill_cap_cfg3 = fill_cap_cfg3;
    next_leak_interval_cfg3 = leak_interval_cfg3;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        // set 2
        lbm_pkg::SET_LVL2_ADDR: next_alarm_set_level_cfg2 = reg_wdata_i;
        lbm_pkg::CLR_LVL2_ADDR: next_alarm_clear_level_cfg2 = reg_wdata_i;
        lbm_pkg::FILL_CAP2_ADDR: next_fill_cap_cfg2 = reg_wdata_i;
        lbm_pkg::LEAK2_ADDR: next_leak_interval_cfg2 = reg_wdata_i[1:0];
        // set 3
        lbm_pkg::SET_LVL3_ADDR: next_alarm_set_level_cfg3 = reg_wdata_i;
        lbm_pkg::CLR_LVL3_ADDR: next_alarm_clear_level_cfg3 = reg_wdata_i;
        lbm_pkg::FILL_CAP3_ADDR: next_fill_cap_cfg3 = reg_wdata_i;
        lbm_pkg::LEAK3_ADDR: next_leak_interval_cfg3 = reg_wdata_i[1:0];
        // unmapped or read-only: ignored
        default: begin
        end
      endcase
    end
  end

  // register reads, one clock latency
  always_comb begin
    next_rdata = rdata;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        // set 2
        lbm_pkg::SET_LVL2_ADDR: next_rdata = alarm_set_level_cfg2;
        lbm_pkg::CLR_LVL2_ADDR: next_rdata = alarm_clear_level_cfg2;
        lbm_pkg::FILL_CAP2_ADDR: next_rdata = fill_cap_cfg2;
        lbm_pkg::LEAK2_ADDR: next_rdata = {6'h00, leak_interval_cfg2};
        // set 3
        lbm_pkg::SET_LVL3_ADDR: next_rdata = alarm_set_level_cfg3;
        lbm_pkg::CLR_LVL3_ADDR: next_rdata = alarm_clear_level_cfg3;
        lbm_pkg::FILL_CAP3_ADDR: next_rdata = fill_cap_cfg3;
        lbm_pkg::LEAK3_ADDR: next_rdata = {6'h00, leak_interval_cfg3};
        // live alarm state
        lbm_pkg::ALARM_STAT_ADDR: next_rdata = alarm_byte(alarm);
        // unmapped reads as zero
        default: next_rdata = lbm_pkg::RDATA_NONE;
      endcase
    end
  end

  // register group flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // documented reset values
      alarm_set_level_cfg2 <= lbm_pkg::SET_LVL_RST;
      alarm_clear_level_cfg2 <= lbm_pkg::CLR_LVL_RST;
      fill_cap_cfg2 <= lbm_pkg::FILL_CAP_RST;
      leak_interval_cfg2 <= lbm_pkg::LEAK_RST;
      alarm_set_level_cfg3 <= lbm_pkg::SET_LVL_RST;
      alarm_clear_level_cfg3 <= lbm_pkg::CLR_LVL_RST;
      fill_cap_cfg3 <= lbm_pkg::FILL_CAP_RST;
      leak_interval_cfg3 <= lbm_pkg::LEAK_RST;
      rdata <= lbm_pkg::RDATA_NONE;
    end else begin
      // take the decoded next values
      alarm_set_level_cfg2 <= next_alarm_set_level_cfg2;
      alarm_clear_level_cfg2 <= next_alarm_clear_level_cfg2;
      fill_cap_cfg2 <= next_fill_cap_cfg2;
      leak_interval_cfg2 <= next_leak_interval_cfg2;
      alarm_set_level_cfg3 <= next_alarm_set_level_cfg3;
      alarm_clear_level_cfg3 <= next_alarm_clear_level_cfg3;
      fill_cap_cfg3 <= next_fill_cap_cfg3;
      leak_interval_cfg3 <= next_leak_interval_cfg3;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // end of evaluation cycle
  assign eval_tick = (eval_cnt == CNT_W'(EVAL_CYCLES - 1));

  // evaluation timer next value
  always_comb begin
    if (eval_tick) begin
      next_eval_cnt = '0;
    end else begin
      next_eval_cnt = CNT_W'(eval_cnt + 1'b1);
    end
  end

  // evaluation timer flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      eval_cnt <= '0;
    end else begin
      eval_cnt <= next_eval_cnt;
    end
  end

  // a fault in the closing clock still counts for that cycle
  // otherwise a fault on the tick clock would fall between cycles
  assign fault_close = fault_seen | fault_i;

  // per-cycle failure capture
  always_comb begin
    if (eval_tick) begin
      next_fault_seen = '0; // fresh cycle
    end else begin
      next_fault_seen = fault_close;
    end
  end

  // failure capture flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fault_seen <= '0;
    end else begin
      fault_seen <= next_fault_seen;
    end
  end

  // one bucket per input, fed by its chosen set
  generate
    for (genvar i = 0; i < NUM_IN; i++) begin : g_bucket
      logic [7:0] set_lvl; // chosen set level
      logic [7:0] clr_lvl; // chosen clear level
      logic [7:0] cap; // chosen fill cap
      logic [1:0] leak; // chosen leak code
      // set 3 where selected, else set 2
      assign set_lvl = cfg3_sel_i[i] ? alarm_set_level_cfg3 : alarm_set_level_cfg2;
      assign clr_lvl = cfg3_sel_i[i] ? alarm_clear_level_cfg3 : alarm_clear_level_cfg2;
      assign cap = cfg3_sel_i[i] ? fill_cap_cfg3 : fill_cap_cfg2;
      assign leak = cfg3_sel_i[i] ? leak_interval_cfg3 : leak_interval_cfg2;
      lbm_bucket u_bucket (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .eval_tick_i(eval_tick),
        .fault_seen_i(fault_close[i]),
        .set_level_i(set_lvl),
        .clear_level_i(clr_lvl),
        .fill_cap_i(cap),
        .leak_code_i(leak),
        .fill_o(),
        .alarm_o(alarm[i])
      );
    end
  endgenerate

  assign alarm_o = alarm;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_tick_wrap: assert property (eval_tick |=> eval_cnt == '0 && !eval_tick)
    else $error("evaluation timer did not wrap");
  a_fault_kept: assert property (!eval_tick && fault_i[0] |=> fault_seen[0])
    else $error("fault lost inside cycle");
  a_leak_bits: assert property (reg_rd_i && reg_addr_i == lbm_pkg::LEAK2_ADDR |=> reg_rdata_o[7:2] == 6'h00)
    else $error("leak register upper bits not zero");
  a_cap_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::FILL_CAP3_ADDR |=>
    fill_cap_cfg3 == $past(reg_wdata_i))
    else $error("cap write lost");
  a_set_apart: assert property (reg_wr_i && reg_addr_i == lbm_pkg::SET_LVL3_ADDR |=>
    $stable(alarm_set_level_cfg2))
    else $error("sets not independent");

  // evaluation timer stays in range and steps by one
  a_tick_range: assert property (eval_cnt <= CNT_W'(EVAL_CYCLES - 1))
    else $error("evaluation timer out of range");
  a_count_step: assert property (!eval_tick |=>
    eval_cnt == CNT_W'($past(eval_cnt) + 1'b1))
    else $error("evaluation timer skipped a count");
  // failure marks clear at the boundary and hold inside a cycle
  a_fault_fresh: assert property (eval_tick |=> fault_seen == '0)
    else $error("failure mark carried into next cycle");
  a_fault_hold: assert property (!eval_tick && fault_seen[0] |=> fault_seen[0])
    else $error("failure mark dropped inside cycle");
  // set 2 registers take their writes
  a_set2_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::SET_LVL2_ADDR |=>
    alarm_set_level_cfg2 == $past(reg_wdata_i))
    else $error("set level 2 write lost");
  a_clr2_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::CLR_LVL2_ADDR |=>
    alarm_clear_level_cfg2 == $past(reg_wdata_i))
    else $error("clear level 2 write lost");
  a_cap2_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::FILL_CAP2_ADDR |=>
    fill_cap_cfg2 == $past(reg_wdata_i))
    else $error("cap 2 write lost");
  a_leak2_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::LEAK2_ADDR |=>
    leak_interval_cfg2 == $past(reg_wdata_i[1:0]))
    else $error("leak 2 write wrong");
  // set 3 clear level and leak registers take their writes
  a_clr3_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::CLR_LVL3_ADDR |=>
    alarm_clear_level_cfg3 == $past(reg_wdata_i))
    else $error("clear level 3 write lost");
  a_leak3_write: assert property (reg_wr_i && reg_addr_i == lbm_pkg::LEAK3_ADDR |=>
    leak_interval_cfg3 == $past(reg_wdata_i[1:0]))
    else $error("leak 3 write wrong");
  // a write to one set leaves the other alone
  a_cap_apart: assert property (reg_wr_i && reg_addr_i == lbm_pkg::FILL_CAP2_ADDR |=>
    $stable(fill_cap_cfg3))
    else $error("cap write crossed sets");
  // the status place takes no writes
  a_stat_ro: assert property (reg_wr_i && reg_addr_i == lbm_pkg::ALARM_STAT_ADDR |=>
    $stable(alarm_set_level_cfg2) && $stable(alarm_set_level_cfg3))
    else $error("status write changed a register");
  // reads: leak bits, config values, status and hold
  a_leak3_bits: assert property (reg_rd_i && reg_addr_i == lbm_pkg::LEAK3_ADDR |=>
    reg_rdata_o[7:2] == 6'h00)
    else $error("leak 3 upper bits not zero");
  a_read_back: assert property (reg_rd_i && reg_addr_i == lbm_pkg::SET_LVL3_ADDR |=>
    reg_rdata_o == $past(alarm_set_level_cfg3))
    else $error("set level 3 read wrong");
  a_stat_read: assert property (reg_rd_i && reg_addr_i == lbm_pkg::ALARM_STAT_ADDR |=>
    reg_rdata_o[NUM_IN-1:0] == $past(alarm))
    else $error("status read wrong");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  c_write_cap: cover property (reg_wr_i && reg_addr_i == lbm_pkg::FILL_CAP2_ADDR);
  c_fault_tick: cover property (eval_tick && fault_i[0]);
endmodule
`default_nettype wire

/* File: dv/tb_leaky_bucket_activity_monitor.sv */
// self-checking testbench for the leaky bucket activity monitor
`timescale 1ns/100ps
`default_nettype none
module tb_leaky_bucket_activity_monitor;
  localparam int EV = 32; // shortened evaluation cycle in clocks
  logic clock_i = 1'b0; // system clock
  logic rst_i = 1'b1; // synchronous reset
  logic reg_wr_i = 1'b0; // write strobe
  logic reg_rd_i = 1'b0; // read strobe
  logic [7:0] reg_addr_i = 8'h00; // register address
  logic [7:0] reg_wdata_i = 8'h00; // write data
  logic [7:0] reg_rdata_o; // read data
  logic [2:0] fault_i = 3'h0; // per input failure marks
  logic [2:0] cfg3_sel_i = 3'h0; // per input config select
  logic [2:0] alarm_o; // per input alarms
  int err_count = 0; // mismatches
  int n_checks = 0; // comparisons
  int cycles = 0; // timeout counter
  int cnt = 0; // mirror of the evaluation timer
  logic [7:0] shadow [8]; // expected register contents
  logic [2:0] fail = 3'h0; // failed marks of the running cycle
  int m_acc [3]; // reference accumulators
  int m_quiet [3]; // reference quiet counts
  logic [2:0] m_alarm = 3'h0; // reference alarms
  lbm_pkg::lbm_byte_type d; // read result

  lbm_monitor #(.NUM_IN(3), .EVAL_CYCLES(EV)) dut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .fault_i(fault_i),
    .cfg3_sel_i(cfg3_sel_i),
    .alarm_o(alarm_o)
  );

  // clock generator, 8 ns period
  always #4 clock_i = ~clock_i;

  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 15000) begin
      err_count++;
      conclude();
    end
  end

  // reference bucket model, updated on each evaluation boundary
  always @(posedge clock_i) begin
    int a, q, c;
    if (rst_i) begin
      cnt <= 0;
      fail <= 3'h0;
      m_alarm <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        m_acc[i] <= 0;
        m_quiet[i] <= 0;
      end
    end else if (cnt == EV - 1) begin
      cnt <= 0;
      fail <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        c = cfg3_sel_i[i] ? 4 : 0;
        a = m_acc[i];
        q = m_quiet[i];
        if (fail[i] | fault_i[i]) begin
          // fill, held at the size limit
          a = (a < int'(shadow[c+2])) ? a + 1 : int'(shadow[c+2]);
          q = 0;
        end else begin
          // leak after 1, 2, 4 or 8 quiet cycles, floor at zero
          q++;
          if (q >= (1 << shadow[c+3][1:0])) begin
            q = 0;
            if (a > 0) a--;
          end
        end
        if (a >= int'(shadow[c])) m_alarm[i] <= 1'b1;
        else if (a <= int'(shadow[c+1])) m_alarm[i] <= 1'b0;
        m_acc[i] <= a;
        m_quiet[i] <= q;
      end
    end else begin
      cnt <= cnt + 1;
      fail <= fail | fault_i;
    end
  end

  // compare one value with its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected read data for an address
  function automatic logic [7:0] exp_reg(input logic [7:0] addr);
    if (addr >= 8'h58 && addr <= 8'h5f) return shadow[addr-8'h58];
    if (addr == lbm_pkg::ALARM_STAT_ADDR) return {5'h00, m_alarm};
    return 8'h00;
  endfunction

  // one register write, called at a falling edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_wr_i = 1'b1;
    reg_addr_i = addr;
    reg_wdata_i = data;
    if (addr >= 8'h58 && addr <= 8'h5f) begin
      // leak selectors keep only their two low bits
      shadow[addr-8'h58] = (addr[1:0] == 2'h3) ? {6'h00, data[1:0]} : data;
    end
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    @(negedge clock_i); // strobe low for one edge before the next write
  endtask

  // one register read, result taken once it is settled
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    reg_rd_i = 1'b1;
    reg_addr_i = addr;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    @(negedge clock_i);
    data = reg_rdata_o;
  endtask

  // reset pulse and shadow defaults
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    shadow = '{8'h06, 8'h04, 8'h08, 8'h01, 8'h06, 8'h04, 8'h08, 8'h01};
  endtask

  // wait for a given timer phase at a falling edge
  task automatic wait_cnt(input int n);
    do @(negedge clock_i); while (cnt != n);
  endtask

  // read back every config register plus unmapped and status places
  task automatic read_all();
    logic [7:0] a;
    logic [7:0] e;
    for (int i = 0; i < 10; i++) begin
      a = i < 8 ? 8'h58 + 8'(i) : (i == 8 ? 8'h60 : 8'h70);
      e = exp_reg(a); // taken before the read edge
      rd(a, d);
      check(d, e);
    end
  endtask

  // final report and verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0] s;
    void'($urandom(32'h7952));
    do_reset();
    read_all();
    // random writes one idle clock apart, also to status and unmapped places
    for (int i = 0; i < 10; i++) wr(i < 8 ? 8'h58 + 8'(i) : (i == 8 ? 8'h60 : 8'h70), 8'($urandom));
    read_all();
    // two rounds: fresh reset, random configurations before the first boundary
    for (int r = 0; r < 2; r++) begin
      cfg3_sel_i = {1'b1, 1'($urandom), 1'b0};
      do_reset();
      for (int c = 0; c < 8; c += 4) begin
        s = 8'h02 + 8'($urandom % 8);
        wr(8'h58 + 8'(c), s);
        wr(8'h59 + 8'(c), 8'($urandom % s));
        wr(8'h5a + 8'(c), c == 0 ? s : s + 8'($urandom % 4));
        // every leak code used once over both rounds, upper bits random
        wr(8'h5b + 8'(c), {6'($urandom), 2'(r * 2 + c / 4)});
      end
      for (int k = 0; k < 150; k++) begin
        wait_cnt(8);
        // heavy failures first to saturate, then sparse ones to drain
        fault_i = (k < 60) ? 3'($urandom | $urandom) : 3'($urandom & $urandom & $urandom);
        wait_cnt(16);
        fault_i = 3'h0;
        wait_cnt(20);
        rd(lbm_pkg::ALARM_STAT_ADDR, d);
        check(d, {5'h00, m_alarm});
        check({5'h00, alarm_o}, {5'h00, m_alarm});
        wr(lbm_pkg::ALARM_STAT_ADDR, 8'($urandom));
      end
      read_all();
    end
    conclude();
  end
endmodule
`default_nettype wire
